// ===== include/alx_pkg.sv
// Behaviour
// RULE_01: Register add sums accumulator and addressed memory byte, updating all five arithmetic flags.
// RULE_02: Destination bit 0 puts the sum in the accumulator; memory stays unchanged.
// RULE_03: Destination bit 1 writes the sum back into the addressed memory byte.
// RULE_04: Bank bit 0 resolves the operand inside the direct-access bank.
// RULE_05: Bank bit 1 joins the bank select register with the operand byte.
// RULE_06: Bank bit 0 with extended set on uses indexed offset for operands up to 95.
// RULE_07: One word, one cycle: decode, operand read, compute, destination write.
// RULE_08: Literal add sums the low instruction byte with the accumulator into it.
// RULE_09: Digit carry from bit 3, carry from bit 7, signed overflow, sign bit 7, zero.
`default_nettype none
package alx_pkg;

  // ***************************************************************
  // Register map.
  // ***************************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_INSN = 8'h04;
  localparam logic [7:0] OFF_ACC = 8'h08;
  localparam logic [7:0] OFF_BANK = 8'h0C;
  localparam logic [7:0] OFF_FLAGS = 8'h10;
  localparam logic [7:0] OFF_INDEX = 8'h14;
  localparam logic [7:0] OFF_INFO = 8'h18;

  localparam int CTRL_GO = 0;
  localparam int CTRL_EXT = 1;
  localparam int INFO_BUSY = 0;
  localparam int INFO_BADOP = 1;

  localparam int FLG_C = 0;
  localparam int FLG_DIGIT_CARRY = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_OVERFLOW = 3;
  localparam int FLG_N = 4;
  localparam int FLG_W = 5;

  // ***************************************************************
  // Widths, reset values and instruction fields.
  // ***************************************************************
  localparam int DATA_W = 8;
  localparam int NIB_W = 4;
  localparam int BANK_W = 4;
  localparam int ADDR_W = 12;
  localparam int INSN_W = 16;

  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [11:0] INDEX_RST = 12'h000;
  localparam logic [15:0] INSN_RST = 16'h0000;

  localparam logic [7:0] OPC_ADD_LIT = 8'h0F;
  localparam logic [5:0] OPC_ADD_REG = 6'h09;
  localparam int DEST_BIT = 9;
  localparam int BANKSEL_BIT = 8;
  localparam logic [7:0] ACCESS_LIMIT = 8'h5F;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_Q1 = 5'h02,
    ST_Q2 = 5'h04,
    ST_Q3 = 5'h08,
    ST_Q4 = 5'h10
  } alx_phase_t;

endpackage
`default_nettype wire

// ===== rtl/alx_adder.sv
`timescale 1ns/10ps
`default_nettype none
module alx_adder (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  output logic [7:0] sum,
  output logic [4:0] flags
);

  logic [alx_pkg::NIB_W:0] low;
  logic [alx_pkg::DATA_W:0] full;

  always_comb begin
    low = {1'b0, a[alx_pkg::NIB_W-1:0]} + {1'b0, b[alx_pkg::NIB_W-1:0]};
    full = {1'b0, a} + {1'b0, b};
    sum = full[alx_pkg::DATA_W-1:0];
    flags = alx_pkg::FLAGS_RST;
    flags[alx_pkg::FLG_DIGIT_CARRY] = low[alx_pkg::NIB_W]; // RULE_09
    flags[alx_pkg::FLG_C] = full[alx_pkg::DATA_W]; // RULE_09
    flags[alx_pkg::FLG_N] = sum[alx_pkg::DATA_W-1]; // RULE_09
    flags[alx_pkg::FLG_Z] = (sum == alx_pkg::ACC_RST); // RULE_09
    flags[alx_pkg::FLG_OVERFLOW] = (a[alx_pkg::DATA_W-1] == b[alx_pkg::DATA_W-1]) &&
                             (sum[alx_pkg::DATA_W-1] != a[alx_pkg::DATA_W-1]); // RULE_09
  end

endmodule
`default_nettype wire

// ===== rtl/alx_bank_resolve.sv
`timescale 1ns/10ps
`default_nettype none
module alx_bank_resolve (
  input wire logic [7:0] operand,
  input wire logic bank_sel,
  input wire logic ext_en,
  input wire logic [3:0] bank_select_register,
  input wire logic [11:0] index_base,
  output logic [11:0] addr
);

  logic low_half;

  always_comb begin
    low_half = (operand <= alx_pkg::ACCESS_LIMIT);
    if (bank_sel) begin
      addr = {bank_select_register, operand}; // RULE_05
    end else if (ext_en && low_half) begin
      addr = index_base + {alx_pkg::ACCESS_LOW_BANK, operand}; // RULE_06
    end else if (low_half) begin
      addr = {alx_pkg::ACCESS_LOW_BANK, operand}; // RULE_04
    end else begin
      addr = {alx_pkg::ACCESS_HIGH_BANK, operand}; // RULE_04
    end
  end

endmodule
`default_nettype wire

// ===== rtl/alx_exec.sv
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module alx_exec (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [11:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  input wire logic [7:0] mem_rdata
);

  // ***************************************************************
  // State of the whole block.
  // ***************************************************************
  typedef struct packed {
    alx_pkg::alx_phase_t phase;
    logic [15:0] insn;
    logic ext_en;
    logic [7:0] acc;
    logic [3:0] bank;
    logic [4:0] flags;
    logic [11:0] index_base;
    logic bad_op;
    logic is_lit;
    logic is_reg;
    logic dest_mem;
    logic [7:0] operand;
    logic [7:0] result;
    logic [4:0] res_flags;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [11:0] mem_addr;
    logic [7:0] mem_wdata;
    logic mem_we;
  } alx_state_t;

  localparam alx_state_t ST_RESET = '{
    phase: alx_pkg::ST_IDLE,
    insn: alx_pkg::INSN_RST,
    ext_en: 1'b0,
    acc: alx_pkg::ACC_RST,
    bank: alx_pkg::BANK_RST,
    flags: alx_pkg::FLAGS_RST,
    index_base: alx_pkg::INDEX_RST,
    bad_op: 1'b0,
    is_lit: 1'b0,
    is_reg: 1'b0,
    dest_mem: 1'b0,
    operand: alx_pkg::ACC_RST,
    result: alx_pkg::ACC_RST,
    res_flags: alx_pkg::FLAGS_RST,
    prdata: 32'h0000_0000,
    pready: 1'b0,
    pslverr: 1'b0,
    mem_addr: 12'h000,
    mem_wdata: alx_pkg::ACC_RST,
    mem_we: 1'b0
  };

  alx_state_t st_q;
  alx_state_t st_d;

  // ***************************************************************
  // Instruction fields of the held word.
  // ***************************************************************
  logic [7:0] insn_opc_lit;
  logic [5:0] insn_opc_reg;
  logic [7:0] insn_byte;
  logic insn_dest;
  logic insn_bank;
  logic insn_known;

  assign insn_opc_lit = st_q.insn[alx_pkg::INSN_W-1:alx_pkg::DATA_W];
  assign insn_opc_reg = st_q.insn[alx_pkg::INSN_W-1:alx_pkg::DEST_BIT+1];
  assign insn_byte = st_q.insn[alx_pkg::DATA_W-1:0];
  assign insn_dest = st_q.insn[alx_pkg::DEST_BIT];
  assign insn_bank = st_q.insn[alx_pkg::BANKSEL_BIT];
  assign insn_known = (insn_opc_lit == alx_pkg::OPC_ADD_LIT) ||
                      (insn_opc_reg == alx_pkg::OPC_ADD_REG);

  // ***************************************************************
  // Arithmetic and address helpers.
  // ***************************************************************
  logic [7:0] sum;
  logic [4:0] sum_flags;
  logic [11:0] res_addr;

  alx_adder u_adder (
    .a(st_q.acc),
    .b(st_q.operand),
    .sum(sum),
    .flags(sum_flags)
  );

  alx_bank_resolve u_resolve (
    .operand(insn_byte),
    .bank_sel(insn_bank),
    .ext_en(st_q.ext_en),
    .bank_select_register(st_q.bank),
    .index_base(st_q.index_base),
    .addr(res_addr)
  );

  // ***************************************************************
  // Next-state logic.
  // ***************************************************************
  logic setup;
  logic wr;
  logic busy;
  logic hit;
  logic locked;
  logic lit_op;
  logic reg_op;

  always_comb begin
    st_d = st_q;
    setup = psel && !penable;
    // A write lands only at the edge that completes an answered, unrefused access.
    wr = psel && penable && st_q.pready && pwrite && !st_q.pslverr;
    busy = (st_q.phase != alx_pkg::ST_IDLE);
    lit_op = (insn_opc_lit == alx_pkg::OPC_ADD_LIT);
    reg_op = (insn_opc_reg == alx_pkg::OPC_ADD_REG);
    hit = 1'b1;
    locked = 1'b0;

    // ***************************************************************
    // Bus answer, prepared in the setup cycle with no wait state.
    // ***************************************************************
    st_d.pready = setup;
    st_d.mem_we = 1'b0;
    if (setup) begin
      st_d.prdata = 32'h0000_0000;
      case (paddr)
        alx_pkg::OFF_CTRL: begin
          st_d.prdata[alx_pkg::CTRL_EXT] = st_q.ext_en;
          locked = busy;
        end
        alx_pkg::OFF_INSN: begin
          st_d.prdata[alx_pkg::INSN_W-1:0] = st_q.insn;
          locked = busy;
        end
        alx_pkg::OFF_ACC: begin
          st_d.prdata[alx_pkg::DATA_W-1:0] = st_q.acc;
          locked = busy;
        end
        alx_pkg::OFF_BANK: begin
          st_d.prdata[alx_pkg::BANK_W-1:0] = st_q.bank;
          locked = busy;
        end
        alx_pkg::OFF_FLAGS: begin
          st_d.prdata[alx_pkg::FLG_W-1:0] = st_q.flags;
          locked = busy;
        end
        alx_pkg::OFF_INDEX: begin
          st_d.prdata[alx_pkg::ADDR_W-1:0] = st_q.index_base;
          locked = busy;
        end
        alx_pkg::OFF_INFO: begin
          st_d.prdata[alx_pkg::INFO_BUSY] = busy;
          st_d.prdata[alx_pkg::INFO_BADOP] = st_q.bad_op;
        end
        default: begin
          hit = 1'b0;
        end
      endcase
      // Writes to execution registers are refused while an instruction runs.
      st_d.pslverr = !hit || (pwrite && locked);
    end else begin
      // Read data and error stand only for the access cycle that they answer.
      st_d.prdata = 32'h0000_0000;
      st_d.pslverr = 1'b0;
    end

    // ***************************************************************
    // Register writes, accepted only while idle except to the info register.
    // ***************************************************************
    if (wr) begin
      case (paddr)
        alx_pkg::OFF_CTRL: begin
          st_d.ext_en = pwdata[alx_pkg::CTRL_EXT];
          // The start bit is a strobe and always reads back as zero.
          if (pwdata[alx_pkg::CTRL_GO]) begin
            st_d.phase = alx_pkg::ST_Q1; // RULE_07
          end
        end
        alx_pkg::OFF_INSN: begin
          st_d.insn = pwdata[alx_pkg::INSN_W-1:0];
        end
        alx_pkg::OFF_ACC: begin
          st_d.acc = pwdata[alx_pkg::DATA_W-1:0];
        end
        alx_pkg::OFF_BANK: begin
          st_d.bank = pwdata[alx_pkg::BANK_W-1:0];
        end
        alx_pkg::OFF_FLAGS: begin
          st_d.flags = pwdata[alx_pkg::FLG_W-1:0];
        end
        alx_pkg::OFF_INDEX: begin
          st_d.index_base = pwdata[alx_pkg::ADDR_W-1:0];
        end
        alx_pkg::OFF_INFO: begin
          // A decode fault in the same cycle sets it again below, so the set wins.
          if (pwdata[alx_pkg::INFO_BADOP]) begin
            st_d.bad_op = 1'b0;
          end
        end
        default: begin
          st_d.bad_op = st_q.bad_op;
        end
      endcase
    end

    // ***************************************************************
    // Four-phase instruction cycle.
    // ***************************************************************
    case (st_q.phase)
      alx_pkg::ST_IDLE: begin
        // Decode results and the data address stay as the last instruction left them.
        st_d.is_lit = st_q.is_lit;
      end
      alx_pkg::ST_Q1: begin
        // Decode and present the resolved data address.
        st_d.is_lit = lit_op; // RULE_07
        st_d.is_reg = reg_op;
        st_d.dest_mem = insn_dest;
        if (insn_known) begin
          st_d.mem_addr = res_addr; // RULE_04 RULE_05 RULE_06
        end else begin
          // An unsupported word changes nothing but its sticky flag.
          st_d.bad_op = 1'b1;
        end
        st_d.phase = alx_pkg::ST_Q2;
      end
      alx_pkg::ST_Q2: begin
        // Fetch the second operand: literal byte or memory byte.
        // The data memory reads combinationally from the address set in the first phase.
        if (st_q.is_lit) begin
          st_d.operand = st_q.insn[alx_pkg::DATA_W-1:0]; // RULE_08
        end else begin
          st_d.operand = mem_rdata; // RULE_01
        end
        st_d.phase = alx_pkg::ST_Q3; // RULE_07
      end
      alx_pkg::ST_Q3: begin
        st_d.result = sum; // RULE_01 RULE_08
        st_d.res_flags = sum_flags;
        if (st_q.is_reg && st_q.dest_mem) begin
          // Memory write strobe stands through the fourth phase.
          st_d.mem_wdata = sum; // RULE_03
          st_d.mem_we = 1'b1; // RULE_03
        end
        st_d.phase = alx_pkg::ST_Q4; // RULE_07
      end
      alx_pkg::ST_Q4: begin
        // Accumulator and flags change together at the end of the write phase.
        if (st_q.is_lit || (st_q.is_reg && !st_q.dest_mem)) begin
          st_d.acc = st_q.result; // RULE_02 RULE_08
        end
        if (st_q.is_lit || st_q.is_reg) begin
          st_d.flags = st_q.res_flags; // RULE_01 RULE_08
        end
        st_d.phase = alx_pkg::ST_IDLE; // RULE_07
      end
      default: begin
        st_d.phase = alx_pkg::ST_IDLE;
      end
    endcase
  end

  // ***************************************************************
  // State register.
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ***************************************************************
  // Outputs, each straight from the state register.
  // ***************************************************************
  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign mem_addr = st_q.mem_addr;
  assign mem_wdata = st_q.mem_wdata;
  assign mem_we = st_q.mem_we;

endmodule
`default_nettype wire

// ===== test/alx_exec_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module alx_exec_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [11:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_we,
  input wire logic [7:0] mem_rdata
);
  // **********
  // Checks.
  // **********
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_go;
    psel && penable && pready && !pslverr && pwrite && paddr == 8'h00 && pwdata[0];
  endsequence
  sequence s_hold;
    $stable(mem_addr) ##1 $stable(mem_addr);
  endsequence
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("ready missing");
  a_ready_gap: assert property (pready |=> !pready)
    else $error("ready too long");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_bad_addr: assert property (psel && !penable && paddr > 8'h18 |=> pslverr && prdata == 32'h0)
    else $error("unmapped address accepted");
  a_early_write: assert property (s_go |=> !mem_we [*3])
    else $error("memory written before last phase");
  a_write_cause: assert property (mem_we |-> $past(psel && penable && pwrite && paddr == 8'h00, 4))
    else $error("memory write without start four cycles before");
  a_write_single: assert property (mem_we |=> !mem_we [*5])
    else $error("write strobe repeated");
  a_addr_held: assert property (s_go ##3 1 |-> s_hold)
    else $error("memory address moved");
endmodule
bind alx_exec alx_exec_asserts i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .mem_addr, .mem_wdata, .mem_we, .mem_rdata);
`default_nettype wire

// ===== test/add_literal_and_register_exec_bench.sv
`timescale 1ns/10ps
`default_nettype none
module add_literal_and_register_exec_bench;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, mem_we, er;
  logic [11:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata;
  logic [7:0] mem [4096];
  logic [31:0] seed = 32'h27;
  int failures = 0;
  int checks = 0;
  int acc, bank, ext, idx, fl, i, f;
  int wq[$];
  // **********
  // Clock, memory and device.
  // **********
  always #50 pclk = ~pclk;
  assign mem_rdata = mem[mem_addr];
  always @(posedge pclk) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
      chk({mem_addr, mem_wdata}, wq.size() > 0 ? wq.pop_front() : -1);
    end
  end
  alx_exec i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mem_addr, .mem_wdata, .mem_we, .mem_rdata);
  // **********
  // Tasks.
  // **********
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 9);
    if (pready !== 1'h1) begin
      failures++;
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic run(input logic [15:0] ins);
    int m, b, s, r, ad, d, lit, ok;
    lit = ins[15:8] == 8'h0F;
    ok = lit || ins[15:10] == 6'h09;
    d = !lit && ins[9];
    if (ins[8]) ad = bank * 256 + ins[7:0];
    else if (ins[7:0] <= 95) ad = ext ? (idx + ins[7:0]) % 4096 : ins[7:0];
    else ad = 3840 + ins[7:0];
    m = mem[ad];
    b = lit ? ins[7:0] : m;
    s = acc + b;
    r = s % 256;
    if (ok && d) wq.push_back(ad * 256 + r);
    apb(1'h1, 8'h04, ins);
    apb(1'h1, 8'h08, acc);
    apb(1'h1, 8'h0C, bank);
    apb(1'h1, 8'h14, idx);
    apb(1'h1, 8'h00, ext * 2 + 1);
    apb(1'h1, 8'h08, 32'h0);
    chk(er, 1);
    apb(1'h0, 8'h18, 32'h0);
    chk(rd, ok ? 0 : 2);
    if (ok) begin
      fl = s / 256 + ((acc % 16 + b % 16) / 16) * 2 + (r == 0) * 4;
      fl = fl + ((acc ^ r) & (b ^ r) & 128) / 16 + (r / 128) * 16;
      if (!d) acc = r;
    end
    apb(1'h0, 8'h08, 32'h0);
    chk(rd, acc);
    apb(1'h0, 8'h10, 32'h0);
    chk(rd, fl);
    chk(mem[ad], ok && d ? r : m);
    if (ok && !lit) chk(mem_addr, ad);
  endtask
  // **********
  // Scenarios.
  // **********
  initial begin
    for (i = 0; i < 4096; i++) mem[i] = 8'(rnd());
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    acc = 0;
    bank = 0;
    ext = 0;
    idx = 0;
    fl = 0;
    apb(1'h0, 8'h40, 32'h0);
    chk(er, 1);
    chk(rd, 0);
    run(16'hFFFF);
    apb(1'h1, 8'h18, 32'h2);
    for (i = 0; i < 80; i++) begin
      acc = rnd() % 256;
      bank = rnd() % 16;
      ext = rnd() % 2;
      idx = rnd() % 4096;
      f = i % 4 == 0 ? 95 : i % 4 == 1 ? 96 : rnd() % 256;
      run(i % 3 == 0 ? {8'h0F, 8'(f)} : {6'h09, 2'(rnd()), 8'(f)});
    end
    chk(wq.size(), 0);
    wrap_up();
  end
endmodule
`default_nettype wire
